// File: design/lou_regs.svh
// opcodes, format masks, status bit positions and constant words for the logic op unit
`ifndef LOU_REGS_SVH
`define LOU_REGS_SVH
`define LOU_OPC_OR_IMM 16'h0260
`define LOU_OPC_XOR 16'h2800
`define LOU_OPC_INVERT 16'h0540
`define LOU_OPC_ZERO_FILL 16'h04C0
`define LOU_OPC_ONES_FILL 16'h0700
`define LOU_OPC_SET_BITS_WORD 16'hE000
`define LOU_OPC_SET_BITS_BYTE 16'hF000
`define LOU_OPC_CLEAR_BITS_WORD 16'h4000
`define LOU_MASK_FMT8 16'hFFF0
`define LOU_MASK_FMT3 16'hFC00
`define LOU_MASK_FMT6 16'hFFC0
`define LOU_MASK_FMT1 16'hF000
`define LOU_ST_LGT 0
`define LOU_ST_AGT 1
`define LOU_ST_EQ 2
`define LOU_ST_PAR 5
`define LOU_ALL_ONES 16'hFFFF
`define LOU_ZERO 16'h0000
`define LOU_ST_RESET 16'h0000
`endif

// File: design/lou_pkg.sv
// types shared by the logic op unit
package lou_pkg;
    typedef enum logic [3:0] {
        LOU_OP_NONE,
        LOU_OP_OR_IMM,
        LOU_OP_XOR,
        LOU_OP_INVERT,
        LOU_OP_ZERO_FILL,
        LOU_OP_ONES_FILL,
        LOU_OP_SET_BITS_WORD,
        LOU_OP_SET_BITS_BYTE,
        LOU_OP_CLEAR_BITS_WORD
    } lou_op_type;
endpackage : lou_pkg

// File: design/lou_core_if.sv
// carrier between the unit sequencer and its arithmetic logic core
`timescale 1ns/10ps
interface lou_core_if;
    import lou_pkg::*;
    lou_op_type op;
    logic [15:0] src;
    logic [15:0] dst;
    logic byte_mode;
    logic [15:0] result;
    logic [15:0] status_in;
    logic [15:0] status_out;
    modport seq (output op, output src, output dst, output byte_mode, output status_in,
        input result, input status_out);
    modport core (input op, input src, input dst, input byte_mode, input status_in,
        output result, output status_out);
endinterface : lou_core_if

// File: design/lou_arith_logic_core.sv
// combinational arithmetic logic core: result word and status update
`timescale 1ns/10ps
`include "lou_regs.svh"
module lou_arith_logic_core
    import lou_pkg::*;
(
    lou_core_if.core cif
);
    logic [15:0] word_res;
    logic [7:0] byte_res;
    logic [15:0] cmp_val;
    logic cmp_flags;
    logic byte_flags;
    logic [15:0] st_cmp;

    always_comb begin
        unique case (cif.op)
            LOU_OP_OR_IMM: word_res = cif.dst | cif.src;
            LOU_OP_XOR: word_res = cif.dst ^ cif.src;
            LOU_OP_INVERT: word_res = ~cif.dst;
            LOU_OP_ZERO_FILL: word_res = `LOU_ZERO;
            LOU_OP_ONES_FILL: word_res = `LOU_ALL_ONES;
            LOU_OP_SET_BITS_WORD: word_res = cif.dst | cif.src;
            LOU_OP_CLEAR_BITS_WORD: word_res = cif.dst & ~cif.src;
            default: word_res = cif.dst;
        endcase
    end

    // byte operand is the high byte; low byte passes through
    assign byte_res = cif.dst[15:8] | cif.src[15:8];
    assign cif.result = cif.byte_mode ? {byte_res, cif.dst[7:0]} : word_res;

    assign byte_flags = cif.byte_mode && cif.op == LOU_OP_SET_BITS_BYTE;
    assign cmp_flags = byte_flags || cif.op inside {LOU_OP_OR_IMM, LOU_OP_XOR,
        LOU_OP_INVERT, LOU_OP_SET_BITS_WORD, LOU_OP_CLEAR_BITS_WORD};
    // byte compare works on the byte placed as a word's top half
    assign cmp_val = byte_flags ? {byte_res, 8'h00} : word_res;

    always_comb begin
        st_cmp = cif.status_in;
        st_cmp[15 - `LOU_ST_LGT] = cmp_val != `LOU_ZERO;
        st_cmp[15 - `LOU_ST_AGT] = !cmp_val[15] && cmp_val != `LOU_ZERO;
        st_cmp[15 - `LOU_ST_EQ] = cmp_val == `LOU_ZERO;
        if (byte_flags) begin
            st_cmp[15 - `LOU_ST_PAR] = ^byte_res;
        end
    end
    // only the compare bits (and parity for bytes) move; others pass
    assign cif.status_out = cmp_flags ? st_cmp : cif.status_in;
endmodule : lou_arith_logic_core

// File: design/lou_logic_op_unit.sv
// logic op unit: decodes the logical group and sequences operand fetch and write-back
`timescale 1ns/10ps
`include "lou_regs.svh"
module lou_logic_op_unit
    import lou_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] instr_addr,
    input wire logic [15:0] wsp_ptr,
    input wire logic [15:0] src_addr,
    input wire logic [15:0] dst_addr,
    input wire logic src_is_reg,
    input wire logic dst_is_reg,
    input wire logic [15:0] status_in,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic [15:0] status_word,
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic mem_wr_hi,
    output logic mem_wr_lo,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    typedef enum logic [2:0] {S_IDLE, S_RD_SRC, S_RD_DST, S_WRITE, S_DONE} lou_state_type;

    lou_core_if cif();
    lou_arith_logic_core u_core (.cif(cif));

    lou_state_type state_reg, state_next;
    lou_op_type op_reg, op_dec;
    logic [15:0] src_reg, dst_reg, waddr_reg, saddr_reg;
    logic byte_reg, uses_src, byte_op;
    logic [15:0] wreg_addr, imm_addr;
    logic [15:0] xor_wreg_addr, src_start_addr, dst_start_addr;
    logic [7:0] wdata_hi;
    logic [12:0] st_rest;
    logic [3:0] wreg_num;

    // decode; format masks select opcode bits
    assign op_dec =
        (instr & `LOU_MASK_FMT8) == `LOU_OPC_OR_IMM ? LOU_OP_OR_IMM :
        (instr & `LOU_MASK_FMT3) == `LOU_OPC_XOR ? LOU_OP_XOR :
        (instr & `LOU_MASK_FMT6) == `LOU_OPC_INVERT ? LOU_OP_INVERT :
        (instr & `LOU_MASK_FMT6) == `LOU_OPC_ZERO_FILL ? LOU_OP_ZERO_FILL :
        (instr & `LOU_MASK_FMT6) == `LOU_OPC_ONES_FILL ? LOU_OP_ONES_FILL :
        (instr & `LOU_MASK_FMT1) == `LOU_OPC_SET_BITS_WORD ? LOU_OP_SET_BITS_WORD :
        (instr & `LOU_MASK_FMT1) == `LOU_OPC_SET_BITS_BYTE ? LOU_OP_SET_BITS_BYTE :
        (instr & `LOU_MASK_FMT1) == `LOU_OPC_CLEAR_BITS_WORD ? LOU_OP_CLEAR_BITS_WORD :
        LOU_OP_NONE;

    assign wreg_num = instr[3:0];
    assign wreg_addr = wsp_ptr + {11'h000, wreg_num, 1'b0};
    assign imm_addr = instr_addr + 16'h0002;
    assign xor_wreg_addr = wsp_ptr + {11'h000, instr[9:6], 1'b0};
    assign src_start_addr = (op_dec == LOU_OP_OR_IMM) ? imm_addr : src_addr;
    assign dst_start_addr = (op_dec == LOU_OP_OR_IMM) ? wreg_addr :
        (op_dec == LOU_OP_XOR) ? xor_wreg_addr : dst_addr;
    assign wdata_hi = mem_wdata[15:8];
    assign st_rest = status_word[12:0];
    assign uses_src = op_reg inside {LOU_OP_OR_IMM, LOU_OP_XOR, LOU_OP_SET_BITS_WORD,
        LOU_OP_SET_BITS_BYTE, LOU_OP_CLEAR_BITS_WORD};
    assign byte_op = op_reg == LOU_OP_SET_BITS_BYTE;

    // core sees next-cycle operands so write data is right from the first write cycle
    assign cif.op = (state_reg == S_IDLE) ? op_dec : op_reg;
    assign cif.src = src_reg;
    assign cif.dst = (state_reg == S_RD_DST && mem_ack) ? mem_rdata : dst_reg;
    assign cif.byte_mode = (state_reg == S_IDLE) ? (op_dec == LOU_OP_SET_BITS_BYTE) :
        byte_reg;
    assign cif.status_in = status_word;

    // fills skip the read entirely: no source and no destination fetch
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: if (start && op_dec != LOU_OP_NONE) begin
                state_next = (op_dec inside {LOU_OP_ZERO_FILL, LOU_OP_ONES_FILL}) ? S_WRITE :
                    (op_dec inside {LOU_OP_INVERT}) ? S_RD_DST : S_RD_SRC;
            end
            S_RD_SRC: if (mem_ack) state_next = S_RD_DST;
            S_RD_DST: if (mem_ack) state_next = S_WRITE;
            S_WRITE: if (mem_ack) state_next = S_DONE;
            S_DONE: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            op_reg <= LOU_OP_NONE;
            src_reg <= `LOU_ZERO;
            dst_reg <= `LOU_ZERO;
            waddr_reg <= `LOU_ZERO;
            saddr_reg <= `LOU_ZERO;
            byte_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_IDLE && start) begin
                op_reg <= op_dec;
                byte_reg <= op_dec == LOU_OP_SET_BITS_BYTE;
                // register operands of word-with-register ops come from the workspace
                saddr_reg <= src_start_addr;
                waddr_reg <= dst_start_addr;
            end
            if (state_reg == S_RD_SRC && mem_ack) src_reg <= mem_rdata;
            if (state_reg == S_RD_DST && mem_ack) dst_reg <= mem_rdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            status_word <= `LOU_ST_RESET;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= `LOU_ZERO;
            mem_wdata <= `LOU_ZERO;
            mem_wr_hi <= 1'b0;
            mem_wr_lo <= 1'b0;
        end else begin
            busy <= state_next != S_IDLE;
            done <= state_next == S_DONE;
            illegal <= state_reg == S_IDLE && start && op_dec == LOU_OP_NONE;
            if (state_reg == S_IDLE && start) status_word <= status_in;
            // status commits with the write-back, never for zero or ones fill
            if (state_reg == S_WRITE && mem_ack) status_word <= cif.status_out;
            mem_rd <= state_next inside {S_RD_SRC, S_RD_DST};
            mem_wr <= state_next == S_WRITE;
            mem_addr <= state_next == S_RD_SRC ?
                (state_reg == S_IDLE ? src_start_addr : saddr_reg) :
                (state_reg == S_IDLE ? dst_start_addr : waddr_reg);
            mem_wdata <= cif.result;
            // byte writes touch only the high byte lane
            mem_wr_hi <= state_next == S_WRITE;
            mem_wr_lo <= state_next == S_WRITE && !(state_reg == S_IDLE ? 1'b0 : byte_op);
        end
    end

    property p_byte_lane;
        @(posedge clk_sys) disable iff (!resetn)
        mem_wr && byte_reg |-> !mem_wr_lo;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte write hit low lane");

    property p_fill_status;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_WRITE && mem_ack && op_reg inside {LOU_OP_ZERO_FILL, LOU_OP_ONES_FILL}
        |=> $stable(status_word);
    endproperty
    a_fill_status: assert property (p_fill_status) else $error("fill changed status");

    sequence s_write_acked;
        state_reg == S_WRITE && mem_ack;
    endsequence

    sequence s_done_pulse;
        done ##1 !done;
    endsequence

    property p_done_after_write;
        @(posedge clk_sys) disable iff (!resetn)
        s_write_acked |=> s_done_pulse;
    endproperty
    a_done_after_write: assert property (p_done_after_write) else $error("done misplaced");

    property p_eq_flag;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_WRITE && mem_ack && op_reg inside {LOU_OP_OR_IMM, LOU_OP_XOR,
        LOU_OP_INVERT, LOU_OP_SET_BITS_WORD} |=> status_word[15 - `LOU_ST_EQ] ==
        ($past(mem_wdata) == `LOU_ZERO);
    endproperty
    a_eq_flag: assert property (p_eq_flag) else $error("equal flag wrong");

    property p_wr_hold;
        @(posedge clk_sys) disable iff (!resetn)
        mem_wr && !mem_ack |=> mem_wr && $stable(mem_addr) && $stable(mem_wdata);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request moved");

    property p_parity;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_WRITE && mem_ack && byte_reg |=>
        status_word[15 - `LOU_ST_PAR] == ^$past(wdata_hi);
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");

    property p_status_mask;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_WRITE && mem_ack && !byte_reg |=> $stable(st_rest);
    endproperty
    a_status_mask: assert property (p_status_mask) else $error("status bits moved");

    property p_illegal_pulse;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_IDLE && start && op_dec == LOU_OP_NONE |=> illegal && !busy;
    endproperty
    a_illegal_pulse: assert property (p_illegal_pulse) else $error("no illegal");

    property p_src_fetch;
        @(posedge clk_sys) disable iff (!resetn)
        state_reg == S_RD_SRC |-> uses_src && mem_rd;
    endproperty
    a_src_fetch: assert property (p_src_fetch) else $error("bad source fetch");
endmodule : lou_logic_op_unit

// File: dv/lou_mem_model.sv
// word memory with byte lanes that answers requests after a set number of wait cycles
`timescale 1ns/10ps
module lou_mem_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_wr_hi,
    input wire logic mem_wr_lo,
    input wire logic [3:0] wait_cycles,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:255];
    logic [3:0] cnt_reg;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'hA5A5;
        end else begin
            mem_ack <= 1'b0;
            // outside an answer the data lines keep changing
            mem_rdata <= ~mem_rdata;
            if ((mem_rd || mem_wr) && !mem_ack) begin
                if (cnt_reg == wait_cycles) begin
                    cnt_reg <= 4'h0;
                    mem_ack <= 1'b1;
                    if (mem_rd) mem_rdata <= mem[mem_addr[8:1]];
                    if (mem_wr && mem_wr_hi) mem[mem_addr[8:1]][15:8] <= mem_wdata[15:8];
                    if (mem_wr && mem_wr_lo) mem[mem_addr[8:1]][7:0] <= mem_wdata[7:0];
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule : lou_mem_model

// File: dv/tb_top.sv
// self-checking testbench for the logic op unit
`timescale 1ns/10ps
module tb_top;
    import lou_pkg::*;
    logic clk_sys, resetn, start, busy, done, illegal, mem_rd, mem_wr, mem_wr_hi, mem_wr_lo;
    logic mem_ack;
    logic [15:0] instr, instr_addr, wsp_ptr, src_addr, dst_addr, status_in, status_word;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, st_seen;
    logic [3:0] wait_cycles;
    int mismatches, check_count;
    lou_logic_op_unit i_lou_logic_op_unit (.clk_sys(clk_sys), .resetn(resetn), .start(start),
        .instr(instr), .instr_addr(instr_addr), .wsp_ptr(wsp_ptr), .src_addr(src_addr),
        .dst_addr(dst_addr), .src_is_reg(1'b0), .dst_is_reg(1'b0), .status_in(status_in),
        .busy(busy), .done(done), .illegal(illegal), .status_word(status_word),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wr_hi(mem_wr_hi), .mem_wr_lo(mem_wr_lo), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    lou_mem_model i_lou_mem_model (.clk_sys(clk_sys), .resetn(resetn), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr_hi(mem_wr_hi),
        .mem_wr_lo(mem_wr_lo), .wait_cycles(wait_cycles), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        check_count++;
        if (seen !== expected) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expected);
        end
    endtask : check
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    function automatic logic [15:0] rd(input logic [15:0] a);
        return i_lou_mem_model.mem[a[8:1]];
    endfunction : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_lou_mem_model.mem[a[8:1]] = d;
    endtask : wr
    // one instruction: start, then wait for done and keep the status seen with it
    task automatic run(input logic [15:0] op, input logic [15:0] st);
        int n;
        @(posedge clk_sys);
        instr <= op;
        status_in <= st;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        #1;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        st_seen = status_word;
        if (n >= 200) mismatches++;
    endtask : run
    task automatic t_or_imm;
        wr(16'h010A, 16'hD2AB);
        wr(16'h0042, 16'h6D03);
        run(16'h0265, 16'h7FFF);
        check(rd(16'h010A), 16'hFFAB);
        check(rd(16'h0042), 16'h6D03);
        check(st_seen, 16'h9FFF);
    endtask : t_or_imm
    task automatic t_xor;
        wr(16'h0104, 16'hD2AA);
        wr(16'h0060, 16'h6D03);
        run(16'h2880, 16'h0000);
        check(rd(16'h0104), 16'hBFA9);
        check(rd(16'h0060), 16'h6D03);
        check(st_seen, 16'h8000);
    endtask : t_xor
    task automatic t_invert;
        wait_cycles <= 4'h3;
        wr(16'h0070, 16'hA54B);
        run(16'h0540, 16'hFFFF);
        check(rd(16'h0070), 16'h5AB4);
        check(st_seen, 16'hDFFF);
        wr(16'h0070, 16'hFFFF);
        run(16'h0540, 16'h0000);
        check(rd(16'h0070), 16'h0000);
        check(st_seen, 16'h2000);
        wait_cycles <= 4'h0;
    endtask : t_invert
    task automatic t_fill;
        dst_addr <= 16'h0072;
        wr(16'h0072, 16'h2001);
        wr(16'h0116, 16'h0073);
        run(16'h04C0, 16'hA5A5);
        check(rd(16'h0072), 16'h0000);
        check(rd(16'h0116), 16'h0073);
        check(st_seen, 16'hA5A5);
        dst_addr <= 16'h0074;
        wr(16'h0074, 16'h3416);
        run(16'h0700, 16'h2000);
        check(rd(16'h0074), 16'hFFFF);
        check(st_seen, 16'h2000);
    endtask : t_fill
    task automatic t_set_clear;
        dst_addr <= 16'h0076;
        wr(16'h0060, 16'hFF00);
        wr(16'h0076, 16'hAAAA);
        run(16'hE000, 16'h0000);
        check(rd(16'h0076), 16'hFFAA);
        check(rd(16'h0060), 16'hFF00);
        check(st_seen, 16'h8000);
        wr(16'h0060, 16'h6D03);
        wr(16'h0076, 16'hD2AA);
        run(16'h4000, 16'h0000);
        check(rd(16'h0076), 16'h92A8);
        check(st_seen, 16'h8000);
    endtask : t_set_clear
    task automatic t_byte;
        src_addr <= 16'h0078;
        dst_addr <= 16'h007A;
        wr(16'h0078, 16'hF013);
        wr(16'h007A, 16'hAA24);
        run(16'hF000, 16'h0400);
        check(rd(16'h007A), 16'hFA24);
        check(st_seen, 16'h8000);
        wr(16'h0078, 16'h0700);
        wr(16'h007A, 16'h00C4);
        run(16'hF000, 16'h0000);
        check(rd(16'h007A), 16'h07C4);
        check(st_seen, 16'hC400);
    endtask : t_byte
    // undecoded opcode, then a start that lands while an invert is busy
    task automatic t_refuse;
        int n;
        dst_addr <= 16'h0070;
        wr(16'h0070, 16'h1234);
        @(posedge clk_sys);
        instr <= 16'h0000;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        check({15'h0000, illegal}, 16'h0001);
        check({15'h0000, busy}, 16'h0000);
        @(posedge clk_sys);
        instr <= 16'h0540;
        start <= 1'b1;
        @(posedge clk_sys);
        instr <= 16'h0000;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        check({15'h0000, illegal}, 16'h0000);
        check({15'h0000, busy}, 16'h0001);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 200) mismatches++;
        check(rd(16'h0070), 16'hEDCB);
    endtask : t_refuse
    initial begin
        resetn = 1'b0;
        start = 1'b0;
        instr = 16'h0000;
        instr_addr = 16'h0040;
        wsp_ptr = 16'h0100;
        src_addr = 16'h0060;
        dst_addr = 16'h0070;
        status_in = 16'h0000;
        wait_cycles = 4'h0;
        mismatches = 0;
        check_count = 0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        t_or_imm();
        t_xor();
        t_invert();
        t_fill();
        t_set_clear();
        t_byte();
        t_refuse();
        stop_test();
    end
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule : tb_top
